// >>> can_status_timing_test_unit_bench.sv
module can_status_timing_test_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic core_tx = 1'b1;
  logic dom = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] obj_pend = 32'h0;
  logic [31:0] prdata, rdata, v, e;
  logic pready, pslverr, perr, can_tx, can_rx, irq, tq_tick, sample_pt;
  logic [2:0] jump_len;
  cst_pkg::cst_evt_t evt = '0;
  cst_pkg::cst_cnt_t cnt = '0;
  cst_pkg::cst_mode_t mode;
  int num_errors = 0;
  int checks = 0;
  int seed = 86938;
  int n, i, j;
  logic [31:0] stat;

  always #5 ref_clk = ~ref_clk;

  cst_core cst_core_inst (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_evt(evt), .i_cnt(cnt),
    .i_obj_pend(obj_pend), .i_can_rx(can_rx), .i_core_tx(core_tx), .o_can_tx(can_tx),
    .o_irq(irq), .o_mode(mode), .o_tq_tick(tq_tick), .o_sample_pt(sample_pt),
    .o_jump_len(jump_len));

  cst_bus_node cst_bus_node_inst (.i_ref_clk(ref_clk), .i_tx(can_tx), .i_dom(dom),
    .o_rx(can_rx));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdata = prdata;
    perr = pslverr;
    if (k >= 50) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd

  // one-cycle engine pulses, then let the flags settle
  task automatic pulse(input logic [7:0] x, input logic [1:0] c);
    @(posedge ref_clk);
    evt <= x;
    cnt <= c;
    @(posedge ref_clk);
    evt <= '0;
    cnt <= '0;
    repeat (3) @(posedge ref_clk);
  endtask : pulse

  // cycles between two pulses of quantum tick or sample point
  task automatic period(input logic sel, output int p);
    int k;
    k = 0;
    p = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while ((sel ? sample_pt : tq_tick) !== 1'b1 && k < 2000);
    do begin
      @(posedge ref_clk);
      p++;
    end while ((sel ? sample_pt : tq_tick) !== 1'b1 && p < 2000);
  endtask : period

  task complete_run;
    $display("mismatches %0d comparisons %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // watchdog, well beyond the expected run of some two thousand cycles
  initial begin
    #400000;
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(cst_pkg::OFS_BTIME, 32'h2301);
    chk({31'h0, mode.init}, 32'h1);
    rd(cst_pkg::OFS_ERR, 32'h0);
    rd(cst_pkg::OFS_IID, 32'h0);
    rd(cst_pkg::OFS_TEST, 32'h80);
    rd(cst_pkg::OFS_PEXT, 32'h0);
    xfer(1'b0, 8'h1c, 32'h0);
    chk({31'h0, perr}, 32'h1);
    // timing writes without change allow are dropped
    v = $random(seed);
    xfer(1'b1, cst_pkg::OFS_CTRL, 32'h01);
    xfer(1'b1, cst_pkg::OFS_BTIME, v);
    xfer(1'b1, cst_pkg::OFS_PEXT, v);
    rd(cst_pkg::OFS_BTIME, 32'h2301);
    rd(cst_pkg::OFS_PEXT, 32'h0);
    xfer(1'b1, cst_pkg::OFS_CTRL, 32'h41);
    xfer(1'b1, cst_pkg::OFS_BTIME, v);
    rd(cst_pkg::OFS_BTIME, v & 32'h7fff);
    xfer(1'b1, cst_pkg::OFS_PEXT, v);
    rd(cst_pkg::OFS_PEXT, v & 32'hf);
    // quantum and bit length with and without extension
    for (i = 0; i < 2; i++) begin
      xfer(1'b1, cst_pkg::OFS_CTRL, 32'h41);
      xfer(1'b1, cst_pkg::OFS_BTIME, 32'h1382);
      xfer(1'b1, cst_pkg::OFS_PEXT, i);
      xfer(1'b1, cst_pkg::OFS_CTRL, 32'h00);
      period(1'b0, n);
      chk(n, 64 * i + 3);
      period(1'b1, n);
      chk(n, (64 * i + 3) * 7);
      chk({29'h0, jump_len}, 32'h3);
    end
    // error codes, each raising and clearing the status interrupt
    xfer(1'b1, cst_pkg::OFS_CTRL, 32'h06);
    xfer(1'b1, cst_pkg::OFS_STAT, 32'h07);
    rd(cst_pkg::OFS_STAT, 32'h07);
    rd(cst_pkg::OFS_IID, 32'h0);
    stat = 32'h07;
    for (j = 0; j < 8; j++) begin
      pulse(8'h80 >> j, 2'b00);
      stat = (stat & 32'hf8) | ((j < 6) ? j + 1 : 0);
      if (j == 6) stat = stat | 32'h10;
      if (j == 7) stat = stat | 32'h08;
      rd(cst_pkg::OFS_IID, 32'h8000);
      chk({31'h0, irq}, 32'h1);
      rd(cst_pkg::OFS_STAT, stat);
      rd(cst_pkg::OFS_IID, 32'h0);
    end
    // counters: warning raises, passive stays silent
    xfer(1'b1, cst_pkg::OFS_CTRL, 32'h0a);
    for (j = 0; j < 12; j++) pulse(8'h00, 2'b01);
    stat = stat | 32'h40;
    rd(cst_pkg::OFS_IID, 32'h8000);
    rd(cst_pkg::OFS_STAT, stat);
    xfer(1'b1, cst_pkg::OFS_CTRL, 32'h06);
    for (j = 0; j < 128; j++) pulse(8'h00, 2'b10);
    stat = stat | 32'h20;
    rd(cst_pkg::OFS_IID, 32'h0);
    rd(cst_pkg::OFS_ERR, 32'hff60);
    rd(cst_pkg::OFS_STAT, stat);
    // object sources under the status interrupt
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      v = v | (32'h1 << (31 - i));
      for (j = 31; j >= 0; j--) if (v[j]) e = j + 1;
      obj_pend <= v;
      repeat (3) @(posedge ref_clk);
      rd(cst_pkg::OFS_IID, e);
      pulse(8'h04, 2'b00);
      stat = (stat & 32'hf8) | 32'h6;
      rd(cst_pkg::OFS_IID, 32'h8000);
      rd(cst_pkg::OFS_STAT, stat);
      rd(cst_pkg::OFS_IID, e);
      chk({31'h0, irq}, 32'h1);
      obj_pend <= 32'h0;
      repeat (3) @(posedge ref_clk);
      rd(cst_pkg::OFS_IID, 32'h0);
    end
    obj_pend <= 32'h1;
    xfer(1'b1, cst_pkg::OFS_CTRL, 32'h04);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    // test register: locked, live pin, pin codes and modes
    xfer(1'b1, cst_pkg::OFS_TEST, 32'h60);
    rd(cst_pkg::OFS_TEST, 32'h80);
    dom <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(cst_pkg::OFS_TEST, 32'h0);
    dom <= 1'b0;
    core_tx <= 1'b0;
    xfer(1'b1, cst_pkg::OFS_CTRL, 32'h80);
    for (i = 0; i < 4; i++) begin
      v = (i << 5) | ((i + 1) << 2);
      xfer(1'b1, cst_pkg::OFS_TEST, v);
      repeat (3) @(posedge ref_clk);
      if (i != 1) chk({31'h0, can_tx}, (i == 3) ? 32'h1 : 32'h0);
      chk({29'h0, mode.loopback, mode.silent, mode.basic}, i + 1);
      xfer(1'b0, cst_pkg::OFS_TEST, 32'h0);
      if (i != 1) chk(rdata, v | ((i == 3) ? 32'h80 : 32'h0));
    end
    complete_run();
  end
endmodule : can_status_timing_test_unit_bench

// >>> cst_bus_node.sv
module cst_bus_node (
  input wire logic i_ref_clk,
  input wire logic i_tx,
  input wire logic i_dom,
  output logic o_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  // wired-and bus with pull-up, one cycle of transceiver delay
  always @(posedge i_ref_clk) begin
    o_rx <= i_tx & ~i_dom;
  end
endmodule : cst_bus_node

// >>> cst_core.sv
// Summary of operation
// RULE1 - stuff error loads error code 1
// RULE2 - form error 2, missing acknowledge 3
// RULE3 - sent recessive, saw dominant: code 4
// RULE4 - sent dominant, saw recessive: 5; recovery too
// RULE5 - checksum mismatch loads error code 6
// RULE6 - software code 7 kept until bus event
// RULE7 - flag changes and updates raise status interrupt
// RULE8 - passive change, software writes raise nothing
// RULE9 - status read clears pending status interrupt
// RULE10 - counter register shows receive and transmit counts
// RULE11 - receive passive flag follows receive count
// RULE12 - segment lengths are field plus one
// RULE13 - jump width, prescaler plus one; quantum division
// RULE14 - bit timing resets to 2301h
// RULE15 - timing writes need change allow and init
// RULE16 - prescaler extension forms upper prescaler bits
// RULE17 - highest priority source reported, status first
// RULE18 - identifier codes none, object, status
// RULE19 - interrupt output while source and enable
// RULE20 - cleared object pending leaves source set; here clearing i_obj_pend drops the source
// RULE21 - test shows receive pin, writes need test
// RULE22 - transmit pin follows pin control code
// RULE23 - loopback, silent, basic mode selection
// RULE24 - error and status enables gate interrupt
// RULE25 - bus-off sets init, 129 idle sequences
//
// The APB interface to the registers was left to the implementer.
module cst_core (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire cst_pkg::cst_evt_t i_evt,
  input wire cst_pkg::cst_cnt_t i_cnt,
  input wire logic [31:0] i_obj_pend,
  input wire logic i_can_rx,
  input wire logic i_core_tx,
  output logic o_can_tx,
  output logic o_irq,
  output cst_pkg::cst_mode_t o_mode,
  output logic o_tq_tick,
  output logic o_sample_pt,
  output logic [2:0] o_jump_len
);
  logic [7:0] ctrl;
  logic [2:0] err_code;
  logic rx_ok;
  logic tx_ok;
  logic [7:0] rx_errs;
  logic [7:0] tx_errs;
  logic [14:0] btime;
  logic [3:0] presc_ext;
  logic [6:2] test_bits;
  logic [15:0] intid;
  logic [15:0] next_intid;
  logic stat_pend;
  logic off_q;
  logic warn_q;
  cst_pkg::cst_off_t off_state;
  logic [3:0] idle_bits;
  logic [7:0] idle_seqs;
  logic [9:0] presc_cnt;
  logic [4:0] tq_cnt;
  logic [31:0] rdata;
  logic mapped;
  logic [2:0] next_err_code;
  logic code_hit;

  // apb decode: a request completes on the edge where pready is seen high
  wire acc = i_psel & i_penable;
  wire done = acc & o_pready;
  function automatic logic sel(input logic [7:0] ofs);
    sel = done && (i_paddr == ofs);
  endfunction : sel
  wire wr_ctrl = sel(cst_pkg::OFS_CTRL) & i_pwrite;
  wire wr_stat = sel(cst_pkg::OFS_STAT) & i_pwrite;
  wire rd_stat = sel(cst_pkg::OFS_STAT) & ~i_pwrite;
  wire wr_btime = sel(cst_pkg::OFS_BTIME) & i_pwrite;
  wire wr_pext = sel(cst_pkg::OFS_PEXT) & i_pwrite;
  wire wr_test = sel(cst_pkg::OFS_TEST) & i_pwrite;
  wire cfg_ok = ctrl[cst_pkg::CTRL_CFG_EN] & ctrl[cst_pkg::CTRL_INIT];

  // error state flags
  wire bus_off = (off_state != cst_pkg::OFF_NONE);
  wire rx_passive = (rx_errs >= cst_pkg::PASS_LIM); // RULE11
  wire err_warn = (rx_errs >= cst_pkg::WARN_LIM) | (tx_errs >= cst_pkg::WARN_LIM);
  wire err_passive = rx_passive | (tx_errs >= cst_pkg::PASS_LIM);
  wire [6:0] rx_errs_disp = rx_passive ? 7'h7f : rx_errs[6:0];
  wire off_enter = i_cnt.tx_err && (tx_errs >= cst_pkg::OFF_LIMIT) && !bus_off;
  wire seq_done = (off_state == cst_pkg::OFF_RECOV) && o_sample_pt && i_can_rx
                  && (idle_bits == cst_pkg::IDLE_BITS - 4'h1);
  wire recov_done = seq_done && (idle_seqs == cst_pkg::IDLE_SEQS - 8'h01);
  wire [1:0] tx_ctl = test_bits[cst_pkg::TEST_TX_LSB +: 2];

  // bit timing fields, each used as value plus one
  wire [9:0] presc = {presc_ext, btime[5:0]}; // RULE16 RULE13
  wire [4:0] sp_idx = {1'b0, btime[11:8]} + 5'h01; // RULE12
  wire [4:0] bit_last = sp_idx + {2'b00, btime[14:12]} + 5'h01; // RULE12

  // apb answer one cycle into the access phase, registered
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= acc & ~o_pready;
      if (acc & ~o_pready) begin
        o_prdata <= i_pwrite ? 32'h0 : rdata;
        o_pslverr <= ~mapped;
      end
    end
  end

  // read mux, reserved bits read zero
  always_comb begin
    rdata = 32'h0;
    mapped = 1'b1;
    case (i_paddr)
      cst_pkg::OFS_CTRL: rdata[7:0] = ctrl;
      cst_pkg::OFS_STAT: rdata[7:0] = {bus_off, err_warn, err_passive, rx_ok, tx_ok, err_code};
      cst_pkg::OFS_ERR: rdata[15:0] = {rx_passive, rx_errs_disp, tx_errs}; // RULE10 RULE11
      cst_pkg::OFS_BTIME: rdata[14:0] = btime;
      cst_pkg::OFS_IID: rdata[15:0] = intid;
      cst_pkg::OFS_TEST: rdata[7:0] = {i_can_rx, test_bits, 2'b00}; // RULE21
      cst_pkg::OFS_PEXT: rdata[3:0] = presc_ext;
      default: mapped = 1'b0;
    endcase
  end

  // control; bus-off forces init and wins over a write
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ctrl <= cst_pkg::RST_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl <= i_pwdata[7:0] & cst_pkg::CTRL_WMASK;
      end
      if (off_enter) begin
        ctrl[cst_pkg::CTRL_INIT] <= 1'b1; // RULE25
      end
    end
  end

  // error code chosen from bus events, first listed wins
  always_comb begin
    code_hit = 1'b1;
    next_err_code = cst_pkg::CODE_NONE;
    if (i_evt.stuff) begin
      next_err_code = cst_pkg::CODE_STUFF; // RULE1
    end else if (i_evt.form) begin
      next_err_code = cst_pkg::CODE_FORM; // RULE2
    end else if (i_evt.ack) begin
      next_err_code = cst_pkg::CODE_ACK; // RULE2
    end else if (i_evt.bit1) begin
      next_err_code = cst_pkg::CODE_BIT1; // RULE3
    end else if (i_evt.bit0 | seq_done) begin
      next_err_code = cst_pkg::CODE_BIT0; // RULE4
    end else if (i_evt.crc) begin
      next_err_code = cst_pkg::CODE_CRC; // RULE5
    end else if (!(i_evt.rx_ok | i_evt.tx_ok)) begin
      code_hit = 1'b0;
    end
  end

  // status fields; hardware update wins over a software write
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      err_code <= cst_pkg::CODE_NONE;
      rx_ok <= 1'b0;
      tx_ok <= 1'b0;
    end else begin
      if (code_hit) begin
        err_code <= next_err_code;
      end else if (wr_stat) begin
        err_code <= i_pwdata[2:0]; // RULE6
      end
      if (i_evt.rx_ok) begin
        rx_ok <= 1'b1;
      end else if (wr_stat) begin
        rx_ok <= i_pwdata[4];
      end
      if (i_evt.tx_ok) begin
        tx_ok <= 1'b1;
      end else if (wr_stat) begin
        tx_ok <= i_pwdata[3];
      end
    end
  end

  // error counters; receive count stops at the passive level
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || recov_done) begin
      rx_errs <= 8'h00; // RULE25
      tx_errs <= 8'h00;
    end else if (!bus_off) begin
      if (i_cnt.rx_err && !rx_passive) begin
        rx_errs <= rx_errs + 8'h01;
      end else if (i_evt.rx_ok && rx_errs != 8'h00) begin
        rx_errs <= rx_errs - 8'h01;
      end
      if (i_cnt.tx_err) begin
        tx_errs <= (tx_errs >= cst_pkg::OFF_LIMIT) ? 8'hff : tx_errs + cst_pkg::TX_ERR_STEP;
      end else if (i_evt.tx_ok && tx_errs != 8'h00) begin
        tx_errs <= tx_errs - 8'h01;
      end
    end
  end

  // bus-off: hold until software drops init, then count idle sequences
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      off_state <= cst_pkg::OFF_NONE;
    end else begin
      case (off_state)
        cst_pkg::OFF_NONE: if (off_enter) off_state <= cst_pkg::OFF_HOLD;
        cst_pkg::OFF_HOLD: if (!ctrl[cst_pkg::CTRL_INIT]) off_state <= cst_pkg::OFF_RECOV;
        cst_pkg::OFF_RECOV: if (recov_done) off_state <= cst_pkg::OFF_NONE; // RULE25
        default: off_state <= cst_pkg::OFF_NONE;
      endcase
    end
  end

  // recessive bit runs; a dominant sample restarts the run
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || off_state != cst_pkg::OFF_RECOV) begin
      idle_bits <= 4'h0;
      idle_seqs <= 8'h00;
    end else if (o_sample_pt) begin
      if (!i_can_rx) begin
        idle_bits <= 4'h0;
      end else if (seq_done) begin
        idle_bits <= 4'h0; // RULE4
        idle_seqs <= idle_seqs + 8'h01; // RULE25
      end else begin
        idle_bits <= idle_bits + 4'h1;
      end
    end
  end

  // timing registers only open during configuration
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      btime <= cst_pkg::RST_BTIME; // RULE14
      presc_ext <= cst_pkg::RST_PEXT;
    end else if (cfg_ok) begin
      if (wr_btime) begin
        btime <= i_pwdata[14:0]; // RULE15
      end
      if (wr_pext) begin
        presc_ext <= i_pwdata[3:0]; // RULE15
      end
    end
  end

  // quantum prescaler; stopped in init so a new setting starts clean
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || ctrl[cst_pkg::CTRL_INIT]) begin
      presc_cnt <= 10'h000;
      o_tq_tick <= 1'b0;
    end else if (presc_cnt == presc) begin
      presc_cnt <= 10'h000; // RULE13
      o_tq_tick <= 1'b1;
    end else begin
      presc_cnt <= presc_cnt + 10'h001;
      o_tq_tick <= 1'b0;
    end
  end

  // quanta within a bit: sync, before-sample, after-sample
  // no resync here; the engine gets the jump width on o_jump_len
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || ctrl[cst_pkg::CTRL_INIT]) begin
      tq_cnt <= 5'h00;
      o_sample_pt <= 1'b0;
    end else begin
      o_sample_pt <= o_tq_tick && (tq_cnt == sp_idx); // RULE12
      if (o_tq_tick) begin
        tq_cnt <= (tq_cnt == bit_last) ? 5'h00 : tq_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_jump_len <= 3'h1;
    end else begin
      o_jump_len <= {1'b0, btime[7:6]} + 3'h1; // RULE13
    end
  end

  // status interrupt sources
  wire err_chg = (bus_off != off_q) | (err_warn != warn_q);
  wire stat_set = (err_chg & ctrl[cst_pkg::CTRL_ERR_EN]) // RULE7 RULE24
                  | (code_hit & ctrl[cst_pkg::CTRL_STAT_EN]); // RULE8
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      off_q <= 1'b0;
      warn_q <= 1'b0;
      stat_pend <= 1'b0;
    end else begin
      off_q <= bus_off;
      warn_q <= err_warn;
      if (stat_set) begin
        stat_pend <= 1'b1; // set beats the read clear
      end else if (rd_stat) begin
        stat_pend <= 1'b0; // RULE9
      end
    end
  end

  // lowest numbered pending object wins; software clears at the source
  function automatic logic [15:0] obj_code(input logic [31:0] pend);
    obj_code = cst_pkg::IID_NONE;
    for (int i = cst_pkg::NUM_OBJ - 1; i >= 0; i--) begin
      if (pend[i]) obj_code = 16'(i + 1);
    end
  endfunction : obj_code

  always_comb begin
    next_intid = stat_pend ? cst_pkg::IID_STATUS // RULE17 RULE18
                           : obj_code(i_obj_pend); // RULE20
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      intid <= cst_pkg::IID_NONE;
      o_irq <= 1'b0;
    end else begin
      intid <= next_intid;
      o_irq <= (next_intid != cst_pkg::IID_NONE) && ctrl[cst_pkg::CTRL_IRQ_EN]; // RULE19
    end
  end

  // test bits drop whenever test mode is left
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || !ctrl[cst_pkg::CTRL_TEST]) begin
      test_bits <= 5'h00;
    end else if (wr_test) begin
      test_bits <= i_pwdata[6:2]; // RULE21
    end
  end

  // transmit pin; under TX_CORE, silent and bus-off keep the pin recessive
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_can_tx <= 1'b1;
    end else begin
      case (tx_ctl)
        cst_pkg::TX_CORE: o_can_tx <= i_core_tx | test_bits[cst_pkg::TEST_SILENT] | bus_off;
        cst_pkg::TX_SAMPLE: o_can_tx <= o_sample_pt; // RULE22
        cst_pkg::TX_DOM: o_can_tx <= 1'b0; // RULE22
        cst_pkg::TX_RECESS: o_can_tx <= 1'b1; // RULE22
        default: o_can_tx <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_mode <= '0;
    end else begin
      o_mode.init <= ctrl[cst_pkg::CTRL_INIT];
      o_mode.dar <= ctrl[cst_pkg::CTRL_DAR];
      o_mode.loopback <= test_bits[cst_pkg::TEST_LOOP]; // RULE23
      o_mode.silent <= test_bits[cst_pkg::TEST_SILENT]; // RULE23
      o_mode.basic <= test_bits[cst_pkg::TEST_BASIC]; // RULE23
    end
  end

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  a_code_stuff: assert property (i_evt.stuff |=> err_code == 3'h1) // RULE1
    else $error("stuff error code not loaded");
  a_code_ackerr: assert property (i_evt.ack && !i_evt.stuff && !i_evt.form
    |=> err_code == 3'h3) // RULE2
    else $error("ack error code not loaded");
  a_code_crc: assert property (i_evt.crc && !(i_evt.stuff | i_evt.form | i_evt.ack
    | i_evt.bit1 | i_evt.bit0 | seq_done) |=> err_code == 3'h6) // RULE5
    else $error("crc error code not loaded");
  a_code_hold: assert property (err_code == 3'h7 && !code_hit && !wr_stat
    |=> $stable(err_code)) // RULE6
    else $error("unused code lost without event");
  a_err_irq: assert property (ctrl[3] && $changed(bus_off)
    |=> stat_pend) // RULE7
    else $error("bus-off change raised no interrupt");
  a_read_clear: assert property (rd_stat && !stat_set
    |=> !stat_pend ##1 intid != 16'h8000) // RULE9
    else $error("status read left interrupt pending");
  a_stat_prio: assert property (stat_pend |=> intid == 16'h8000) // RULE17
    else $error("status interrupt not reported first");
  a_cfg_lock: assert property (wr_btime && !cfg_ok |=> $stable(btime)) // RULE15
    else $error("locked timing register changed");
  a_irq_gate: assert property (o_irq |-> intid != 16'h0000 && $past(ctrl[1])) // RULE19
    else $error("irq without source or enable");
  a_tx_force: assert property (tx_ctl == 2'h2 |=> !o_can_tx) // RULE22
    else $error("forced dominant not driven");
  a_recov_end: assert property (recov_done
    |=> rx_errs == 8'h00 && tx_errs == 8'h00 && !bus_off) // RULE25
    else $error("recovery did not reset counters");

  c_stat_irq: cover property (stat_pend && o_irq);
  c_recov: cover property (recov_done);
  c_loopback: cover property (o_sample_pt && o_mode.loopback);
endmodule : cst_core

// >>> cst_pkg.sv
package cst_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_ERR = 8'h08;
  localparam logic [7:0] OFS_BTIME = 8'h0c;
  localparam logic [7:0] OFS_IID = 8'h10;
  localparam logic [7:0] OFS_TEST = 8'h14;
  localparam logic [7:0] OFS_PEXT = 8'h18;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h01;
  localparam logic [14:0] RST_BTIME = 15'h2301;
  localparam logic [3:0] RST_PEXT = 4'h0;
  // control fields
  localparam int CTRL_INIT = 0;
  localparam int CTRL_IRQ_EN = 1;
  localparam int CTRL_STAT_EN = 2;
  localparam int CTRL_ERR_EN = 3;
  localparam int CTRL_DAR = 5;
  localparam int CTRL_CFG_EN = 6;
  localparam int CTRL_TEST = 7;
  localparam logic [7:0] CTRL_WMASK = 8'hef;
  // test fields
  localparam int TEST_BASIC = 2;
  localparam int TEST_SILENT = 3;
  localparam int TEST_LOOP = 4;
  localparam int TEST_TX_LSB = 5;
  // error limits and bus-off recovery
  localparam logic [7:0] WARN_LIM = 8'h60;
  localparam logic [7:0] PASS_LIM = 8'h80;
  localparam logic [7:0] TX_ERR_STEP = 8'h08;
  localparam logic [7:0] OFF_LIMIT = 8'hf8;
  localparam logic [3:0] IDLE_BITS = 4'hb;
  localparam logic [7:0] IDLE_SEQS = 8'h81;
  // error codes
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_STUFF = 3'h1;
  localparam logic [2:0] CODE_FORM = 3'h2;
  localparam logic [2:0] CODE_ACK = 3'h3;
  localparam logic [2:0] CODE_BIT1 = 3'h4;
  localparam logic [2:0] CODE_BIT0 = 3'h5;
  localparam logic [2:0] CODE_CRC = 3'h6;
  localparam logic [2:0] CODE_UNUSED = 3'h7;
  // interrupt identifiers and pin control codes
  localparam logic [15:0] IID_NONE = 16'h0000;
  localparam logic [15:0] IID_STATUS = 16'h8000;
  localparam int NUM_OBJ = 32;
  localparam logic [1:0] TX_CORE = 2'h0;
  localparam logic [1:0] TX_SAMPLE = 2'h1;
  localparam logic [1:0] TX_DOM = 2'h2;
  localparam logic [1:0] TX_RECESS = 2'h3;

  typedef enum logic [1:0] {
    OFF_NONE = 2'b00,
    OFF_HOLD = 2'b01,
    OFF_RECOV = 2'b10
  } cst_off_t;

  // bus events from the protocol engine, one-cycle pulses
  typedef struct packed {
    logic stuff;
    logic form;
    logic ack;
    logic bit1;
    logic bit0;
    logic crc;
    logic rx_ok;
    logic tx_ok;
  } cst_evt_t;

  // error counter steps, one-cycle pulses
  typedef struct packed {
    logic rx_err;
    logic tx_err;
  } cst_cnt_t;

  typedef struct packed {
    logic init;
    logic dar;
    logic loopback;
    logic silent;
    logic basic;
  } cst_mode_t;
endpackage : cst_pkg
